// [hdl/lepsc_pkg.sv]
// package: register map, field positions, timing and carrier types of the led engine power-save control
package lepsc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_ENABLE = 10'h000;
	localparam logic [9:0] IDX_PWR_CFG = 10'h036;
	localparam logic [9:0] IDX_DIRECT = 10'h070;
	localparam logic [9:0] IDX_STATUS = 10'h071;

	// power configuration fields
	localparam int BIT_EXT_CLK = 0;
	localparam int BIT_PWM_SAVE = 2;
	localparam int BIT_AUTO_IDLE = 5;
	// enable register field
	localparam int BIT_CHIP_EN = 0;
	// direct drive fields
	localparam int POS_LVL8 = 0;
	localparam int POS_LVL9 = 8;
	localparam int BIT_DIR8 = 16;
	localparam int BIT_DIR9 = 17;
	// status fields
	localparam int POS_ST_MODE = 0;
	localparam int POS_ST_PWR = 2;
	localparam int BIT_ST_HELD = 7;
	localparam int BIT_ST_SEND = 8;

	// values after reset
	localparam logic RST_CHIP_EN = 1'b0;
	localparam logic RST_AUTO_IDLE = 1'b0;
	localparam logic RST_PWM_SAVE = 1'b0;
	localparam logic RST_EXT_CLK = 1'b0;
	localparam logic [7:0] RST_LEVEL = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ = 200_000_000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int IDLE_MIN_MS = 50;
	localparam int IDLE_MIN_CYC = IDLE_MIN_MS * (1_000_000 / CLK_PERIOD_NS);
	localparam int SLOW_CLK_HZ = 32768;
	localparam int SLOW_TICK_CYC = CLK_HZ / SLOW_CLK_HZ;
	localparam int WAKE_NS = 100;
	localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_TRIGGER_PIN_OUT_TICKS = 3;
	localparam int SYNC_TRIGGER_PIN_IN_TICKS = 2;
	localparam int NUM_ENGINES = 3;
	localparam int NUM_OUTPUTS = 9;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {MODE_ACTIVE, MODE_IDLE, MODE_WAKE} lepsc_mode_e;

	typedef struct packed {
		logic analogOn;
		logic cpOn;
		logic cpWeak1x;
		logic ledDrvOn;
		logic cpProtOn;
	} lepsc_pwr_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lepsc_apb_req_s;

endpackage : lepsc_pkg

// [hdl/lepsc_power_save.sv]
// module: power-save sequencing, trigger pin and direct drive for a three-engine led driver
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - idle power-down only with auto idle bit
// - external clock idle: all analog off except protection
// - internal clock idle: charge pump, drivers off
// - idle puts charge pump in weak 1x
// - enter idle only above 50 ms look-ahead
// - look-ahead checks all three engines
// - engines keep running during idle
// - pwm demand in idle starts fast wake-up
// - off-phase saving only with its enable bit
// - off-phase blocks chosen by clock source
// - off-phase saving with engines or direct control
// - trigger and notify pins are open-drain
// - trigger low starts sequence; rearm after release
// - outputs eight and nine directly register driven
module lepsc_power_save
	import lepsc_pkg::*;
#(
	parameter int IDLE_MIN = IDLE_MIN_CYC,
	parameter int SLOW_TICK = SLOW_TICK_CYC,
	parameter int IDLE_W = 24
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb slave
	input wire lepsc_apb_req_s apbReq,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// engine look-ahead and activity
	input wire logic [NUM_ENGINES-1:0][IDLE_W-1:0] engIdleCyc,
	input wire logic [NUM_ENGINES-1:0] engPwmReq,
	input wire logic [NUM_OUTPUTS-1:0] pwmOn,
	input wire logic [7:0] engLevel8,
	input wire logic [7:0] engLevel9,
	input wire logic engSendTrig,
	input wire logic notifyReq,
	// power control
	output lepsc_pwr_s pwrCtl,
	output logic wakeStart,
	output logic engineRun,
	// direct drive of outputs eight and nine
	output logic [7:0] currentOutputEight,
	output logic [7:0] currentOutputNine,
	// open-drain pins
	input wire logic syncTriggerPinIn,
	output logic syncTriggerPinOut,
	output logic syncTriggerPinOe_b,
	output logic notifyPinOut,
	output logic notifyPinOe_b,
	output logic triggerFire
);

	typedef struct packed {
		lepsc_mode_e mode;
		logic chipEn;
		logic autoIdleEn;
		logic pwmSaveEn;
		logic extClk;
		logic [7:0] lvl8;
		logic [7:0] lvl9;
		logic dir8;
		logic dir9;
		logic [7:0] out8;
		logic [7:0] out9;
		lepsc_pwr_s pwr;
		logic [7:0] wakeCnt;
		logic [15:0] tickCnt;
		logic [1:0] sendCnt;
		logic [1:0] lowCnt;
		logic trigHeld;
		logic trigFire;
		logic wakeStart;
		logic notifyOe_b;
		logic [31:0] prdata;
	} lepsc_state_s;

	lepsc_state_s st_r;
	lepsc_state_s st_nxt;
	logic [NUM_ENGINES-1:0] engQuiet;
	logic allQuiet;
	logic tick;
	logic setup;
	logic wrEn;
	logic [9:0] idx;
	logic mapped;
	lepsc_pwr_s pwrSaved;
	lepsc_pwr_s pwrFull;

	////////////////////////////////////////////////////////////////////////////////
	// look-ahead over every engine's pending idle interval
	generate
		for (genvar e = 0; e < NUM_ENGINES; e++) begin : g_eng
			assign engQuiet[e] = engIdleCyc[e] > IDLE_W'(IDLE_MIN);
		end
	endgenerate
	assign allQuiet = &engQuiet && !(|pwmOn) && !(|engPwmReq);

	assign tick = st_r.tickCnt == 16'(SLOW_TICK - 1);
	assign setup = apbReq.psel && !apbReq.penable;
	assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign idx = apbReq.paddr[11:2];
	assign mapped = idx == IDX_ENABLE || idx == IDX_PWR_CFG || idx == IDX_DIRECT
		|| idx == IDX_STATUS;

	assign pready = 1'b1;
	assign pslverr = apbReq.psel && apbReq.penable && !mapped;

	always_comb begin
		pwrFull = '{analogOn: 1'b1, cpOn: 1'b1, cpWeak1x: 1'b0, ledDrvOn: 1'b1, cpProtOn: 1'b1};
		if (st_r.extClk) begin
			// only the charge pump guard stays alive on external clock
			pwrSaved = '{analogOn: 1'b0, cpOn: 1'b0, cpWeak1x: 1'b1, ledDrvOn: 1'b0,
				cpProtOn: 1'b1};
		end else begin
			// internal oscillator and digital core must stay up
			pwrSaved = '{analogOn: 1'b1, cpOn: 1'b0, cpWeak1x: 1'b1, ledDrvOn: 1'b0,
				cpProtOn: 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.trigFire = 1'b0;
		st_nxt.wakeStart = 1'b0;
		st_nxt.tickCnt = tick ? 16'h0000 : st_r.tickCnt + 16'h0001;

		// register writes
		if (wrEn) begin
			case (idx)
				IDX_ENABLE: begin
					st_nxt.chipEn = apbReq.pwdata[BIT_CHIP_EN];
				end
				IDX_PWR_CFG: begin
					st_nxt.autoIdleEn = apbReq.pwdata[BIT_AUTO_IDLE];
					st_nxt.pwmSaveEn = apbReq.pwdata[BIT_PWM_SAVE];
					st_nxt.extClk = apbReq.pwdata[BIT_EXT_CLK];
				end
				IDX_DIRECT: begin
					st_nxt.lvl8 = apbReq.pwdata[POS_LVL8+:8];
					st_nxt.lvl9 = apbReq.pwdata[POS_LVL9+:8];
					st_nxt.dir8 = apbReq.pwdata[BIT_DIR8];
					st_nxt.dir9 = apbReq.pwdata[BIT_DIR9];
				end
				default: begin
				end
			endcase
		end

		// read data captured in setup so it stands through the access phase
		if (setup) begin
			st_nxt.prdata = 32'h0000_0000;
			case (idx)
				IDX_ENABLE: st_nxt.prdata[BIT_CHIP_EN] = st_r.chipEn;
				IDX_PWR_CFG: begin
					st_nxt.prdata[BIT_AUTO_IDLE] = st_r.autoIdleEn;
					st_nxt.prdata[BIT_PWM_SAVE] = st_r.pwmSaveEn;
					st_nxt.prdata[BIT_EXT_CLK] = st_r.extClk;
				end
				IDX_DIRECT: begin
					st_nxt.prdata[POS_LVL8+:8] = st_r.lvl8;
					st_nxt.prdata[POS_LVL9+:8] = st_r.lvl9;
					st_nxt.prdata[BIT_DIR8] = st_r.dir8;
					st_nxt.prdata[BIT_DIR9] = st_r.dir9;
				end
				IDX_STATUS: begin
					st_nxt.prdata[POS_ST_MODE+:2] = st_r.mode;
					st_nxt.prdata[POS_ST_PWR+:5] = st_r.pwr;
					st_nxt.prdata[BIT_ST_HELD] = st_r.trigHeld;
					st_nxt.prdata[BIT_ST_SEND] = ~syncTriggerPinOe_b;
				end
				default: begin
				end
			endcase
		end

		// idle power-down sequencing; engines are never stalled here
		case (st_r.mode)
			MODE_ACTIVE: begin
				if (st_r.chipEn && st_r.autoIdleEn && allQuiet) begin
					st_nxt.mode = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (|engPwmReq || !st_r.autoIdleEn || !st_r.chipEn) begin
					st_nxt.mode = MODE_WAKE;
					st_nxt.wakeStart = 1'b1;
					st_nxt.wakeCnt = 8'(WAKE_CYC - 1);
				end
			end
			MODE_WAKE: begin
				if (st_r.wakeCnt == 8'h00) begin
					st_nxt.mode = MODE_ACTIVE;
				end else begin
					st_nxt.wakeCnt = st_r.wakeCnt - 8'h01;
				end
			end
			default: begin
				st_nxt.mode = MODE_ACTIVE;
			end
		endcase

		// power selection: all off without chip enable, idle, off-phase, or fully on
		if (!st_nxt.chipEn) begin
			st_nxt.pwr = '0;
		end else if (st_nxt.mode == MODE_IDLE) begin
			st_nxt.pwr = pwrSaved;
		end else if (st_nxt.mode == MODE_ACTIVE && st_r.pwmSaveEn && !(|pwmOn)) begin
			// off-phase only: current level itself is never touched
			st_nxt.pwr = pwrSaved;
		end else begin
			st_nxt.pwr = pwrFull;
		end

		// outputs eight and nine from register or engine
		st_nxt.out8 = st_r.dir8 ? st_r.lvl8 : engLevel8;
		st_nxt.out9 = st_r.dir9 ? st_r.lvl9 : engLevel9;

		// trigger send: own pulse is masked from our own detector
		if (engSendTrig && st_r.sendCnt == 2'd0) begin
			st_nxt.sendCnt = 2'(SYNC_TRIGGER_PIN_OUT_TICKS);
		end else if (tick && st_r.sendCnt != 2'd0) begin
			st_nxt.sendCnt = st_r.sendCnt - 2'd1;
		end

		// trigger receive: low for two slow ticks fires once, rearms on release
		if (syncTriggerPinIn) begin
			st_nxt.lowCnt = 2'd0;
			st_nxt.trigHeld = 1'b0;
		end else if (tick && st_r.sendCnt == 2'd0 && !st_r.trigHeld) begin
			if (st_r.lowCnt == 2'(SYNC_TRIGGER_PIN_IN_TICKS - 1)) begin
				st_nxt.trigFire = 1'b1;
				st_nxt.trigHeld = 1'b1;
				st_nxt.lowCnt = 2'd0;
			end else begin
				st_nxt.lowCnt = st_r.lowCnt + 2'd1;
			end
		end

		st_nxt.notifyOe_b = !notifyReq;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{mode: MODE_ACTIVE, chipEn: RST_CHIP_EN, autoIdleEn: RST_AUTO_IDLE,
				pwmSaveEn: RST_PWM_SAVE, extClk: RST_EXT_CLK, lvl8: RST_LEVEL, lvl9: RST_LEVEL,
				notifyOe_b: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign prdata = st_r.prdata;
	assign pwrCtl = st_r.pwr;
	assign wakeStart = st_r.wakeStart;
	assign engineRun = st_r.chipEn;
	assign currentOutputEight = st_r.out8;
	assign currentOutputNine = st_r.out9;
	assign syncTriggerPinOut = 1'b0;
	assign syncTriggerPinOe_b = st_r.sendCnt == 2'd0;
	assign notifyPinOut = 1'b0;
	assign notifyPinOe_b = st_r.notifyOe_b;
	assign triggerFire = st_r.trigFire;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_idle_needs_auto: assert property ($rose(st_r.mode == MODE_IDLE) |-> $past(st_r.autoIdleEn))
		else $error("idle entered without auto idle enable");
	a_ext_idle_pwr: assert property (st_r.mode == MODE_IDLE && st_r.chipEn && st_r.extClk
		&& $past(st_r.extClk) |-> !pwrCtl.analogOn && pwrCtl.cpProtOn && !pwrCtl.ledDrvOn)
		else $error("external clock idle left analog powered");
	a_int_idle_pwr: assert property (st_r.mode == MODE_IDLE && st_r.chipEn && !st_r.extClk
		&& $past(!st_r.extClk) |-> pwrCtl.analogOn && !pwrCtl.cpOn && !pwrCtl.ledDrvOn)
		else $error("internal clock idle power wrong");
	a_idle_weak_cp: assert property (st_r.mode == MODE_IDLE && st_r.chipEn |-> pwrCtl.cpWeak1x)
		else $error("charge pump not weak in idle");
	a_idle_entry_cond: assert property ($rose(st_r.mode == MODE_IDLE)
		|-> $past(engIdleCyc[0] > IDLE_W'(IDLE_MIN) && engIdleCyc[1] > IDLE_W'(IDLE_MIN)
		&& engIdleCyc[2] > IDLE_W'(IDLE_MIN) && pwmOn == '0))
		else $error("idle entered with short look-ahead");
	// a host write that clears chip enable lands one cycle before idle is left
	a_run_in_idle: assert property (st_r.mode == MODE_IDLE && !$past(wrEn) |-> engineRun)
		else $error("engines stopped in idle");
	a_wake_on_pwm: assert property (st_r.mode == MODE_IDLE && |engPwmReq
		|=> st_r.mode == MODE_WAKE && wakeStart ##1 (st_r.mode == MODE_WAKE)[*8])
		else $error("pwm demand did not start wake-up");
	a_wake_ends: assert property ($rose(st_r.mode == MODE_WAKE) |-> ##[1:40] st_r.mode == MODE_ACTIVE)
		else $error("wake-up did not finish");
	a_offphase_gate: assert property (st_r.mode == MODE_ACTIVE && st_r.chipEn
		&& $past(st_r.mode) == MODE_ACTIVE && !pwrCtl.ledDrvOn |-> $past(st_r.pwmSaveEn))
		else $error("drivers off without off-phase enable");
	a_offphase_cut: assert property (st_r.mode == MODE_ACTIVE && st_r.chipEn
		&& st_r.pwmSaveEn && !st_r.autoIdleEn && pwmOn == '0 && !wrEn
		|=> !pwrCtl.ledDrvOn && !pwrCtl.cpOn)
		else $error("off-phase did not cut blocks");
	a_sync_trigger_pin_pulse_len: assert property ($fell(syncTriggerPinOe_b) |-> !syncTriggerPinOe_b[*8])
		else $error("sent trigger too short");
	a_sync_trigger_pin_fire_low: assert property (triggerFire
		|-> $past(!syncTriggerPinIn) && $past(syncTriggerPinOe_b) ##1 !triggerFire)
		else $error("trigger fired without low pin");
	a_direct_drive: assert property (st_r.dir8 && !wrEn |=> currentOutputEight == $past(st_r.lvl8))
		else $error("direct output eight not from register");
	a_all_on: assert property (st_r.chipEn && !st_r.pwmSaveEn && !st_r.autoIdleEn && !wrEn
		&& st_r.mode == MODE_ACTIVE |=> pwrCtl == lepsc_pwr_s'{1'b1, 1'b1, 1'b0, 1'b1, 1'b1})
		else $error("blocks powered down with saving off");

	c_enter_idle: cover property ($rose(st_r.mode == MODE_IDLE));
	c_wake_done: cover property (st_r.mode == MODE_WAKE ##1 st_r.mode == MODE_ACTIVE);
	c_trigger: cover property (triggerFire);
	c_offphase: cover property (st_r.mode == MODE_ACTIVE && st_r.chipEn && !pwrCtl.ledDrvOn);

endmodule : lepsc_power_save

// [tb/lepsc_host_model.sv]
// host processor model: apb master transfers and open-drain trigger pull
`timescale 1ns/1ps
module lepsc_host_model
	import lepsc_pkg::*;
#(
	parameter int SLOW_TICK = 4
) (
	// clock
	input wire logic sys_clk,
	// apb master
	output lepsc_apb_req_s apbReq,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// trigger pin, high means pulling it low
	output logic trigPull
);
	initial begin
		apbReq = '0;
		trigPull = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdat,
		output logic [31:0] rdat, output logic err);
		@(posedge sys_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdat};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		apbReq <= '0;
	endtask : xfer

	// three slow ticks, one more than the device needs, so a partial first tick is harmless
	task pullTrig();
		trigPull <= 1'b1;
		repeat (3 * SLOW_TICK) @(posedge sys_clk);
		trigPull <= 1'b0;
	endtask : pullTrig
endmodule : lepsc_host_model

// [tb/lepsc_power_save_bench.sv]
// bench for the led engine power-save control
`timescale 1ns/1ps
module lepsc_power_save_bench
	import lepsc_pkg::*;
;
	localparam int TICK = 4;
	localparam logic [11:0] A_EN = {IDX_ENABLE, 2'b00};
	localparam logic [11:0] A_CFG = {IDX_PWR_CFG, 2'b00};
	localparam logic [11:0] A_DIR = {IDX_DIRECT, 2'b00};
	localparam logic [11:0] A_ST = {IDX_STATUS, 2'b00};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	lepsc_apb_req_s apbReq;
	logic pready, pslverr, err, trigPull, pinLvl, engSendTrig, notifyReq;
	logic [31:0] prdata, rd;
	logic [NUM_ENGINES-1:0][23:0] engIdleCyc;
	logic [2:0] engPwmReq;
	logic [8:0] pwmOn;
	logic [7:0] engLevel8, engLevel9, currentOutputEight, currentOutputNine;
	lepsc_pwr_s pwrCtl;
	logic wakeStart, engineRun, syncTriggerPinOut, syncTriggerPinOe_b;
	logic notifyPinOut, notifyPinOe_b, triggerFire;
	int mismatches = 0, nTests = 0, fires = 0, wakes = 0, lowCyc = 0, f, w;

	always #2.5 sys_clk = ~sys_clk;
	// pull-up: the pin is low only while some party pulls it
	assign pinLvl = ~trigPull & syncTriggerPinOe_b;

	always @(posedge sys_clk) begin
		if (triggerFire === 1'b1) fires++;
		if (wakeStart === 1'b1) wakes++;
		if (syncTriggerPinOe_b === 1'b0) lowCyc++;
	end

	lepsc_power_save #(.IDLE_MIN(20), .SLOW_TICK(TICK), .IDLE_W(24)) u_lepsc_power_save (
		.sys_clk(sys_clk), .rst_b(rst_b), .apbReq(apbReq), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .engIdleCyc(engIdleCyc),
		.engPwmReq(engPwmReq), .pwmOn(pwmOn), .engLevel8(engLevel8),
		.engLevel9(engLevel9), .engSendTrig(engSendTrig), .notifyReq(notifyReq),
		.pwrCtl(pwrCtl), .wakeStart(wakeStart), .engineRun(engineRun),
		.currentOutputEight(currentOutputEight), .currentOutputNine(currentOutputNine),
		.syncTriggerPinIn(pinLvl), .syncTriggerPinOut(syncTriggerPinOut),
		.syncTriggerPinOe_b(syncTriggerPinOe_b), .notifyPinOut(notifyPinOut),
		.notifyPinOe_b(notifyPinOe_b), .triggerFire(triggerFire));

	lepsc_host_model #(.SLOW_TICK(TICK)) u_lepsc_host_model (
		.sys_clk(sys_clk), .apbReq(apbReq), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .trigPull(trigPull));

	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task chkPwr(input logic [4:0] exp);
		chk({27'h0, pwrCtl}, {27'h0, exp});
	endtask : chkPwr

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task wr(input logic [11:0] a, input logic [31:0] d);
		u_lepsc_host_model.xfer(1'b1, a, d, rd, err);
	endtask : wr

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		u_lepsc_host_model.xfer(1'b0, a, 32'h0, rd, err);
		chk(rd, exp);
	endtask : rdc

	////////////////////////////////////////////////////////////////////////////////
	task testRegs();
		rdc(A_CFG, 32'h0);
		rdc(A_EN, 32'h0);
		wr(A_EN, 32'h1);
		wr(A_CFG, 32'h24);
		rdc(A_CFG, 32'h24);
		wr(A_CFG, 32'h0);
		u_lepsc_host_model.xfer(1'b0, 12'h3fc, 32'h0, rd, err);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		wr(A_ST, 32'hffffffff);
		rdc(A_ST, 32'h6c);
	endtask : testRegs

	task testIdle();
		pwmOn <= 9'h000;
		wr(A_CFG, 32'h20);
		engIdleCyc <= {24'd21, 24'd20, 24'd21};
		tick(4);
		chkPwr(5'h1b);
		engIdleCyc <= {3{24'd21}};
		tick(3);
		chkPwr(5'h15);
		chk({31'h0, engineRun}, 32'h1);
		w = wakes;
		engPwmReq <= 3'b010;
		tick(25);
		chk(wakes - w, 32'h1);
		chkPwr(5'h1b);
		engPwmReq <= 3'b000;
		engIdleCyc <= '0;
		wr(A_CFG, 32'h21);
		engIdleCyc <= {3{24'd21}};
		tick(3);
		chkPwr(5'h05);
		wr(A_CFG, 32'h0);
		tick(25);
		chkPwr(5'h1b);
	endtask : testIdle

	task testOffPhase();
		wr(A_CFG, 32'h4);
		tick(2);
		chkPwr(5'h15);
		pwmOn <= 9'h100;
		tick(2);
		chkPwr(5'h1b);
		pwmOn <= 9'h000;
		wr(A_CFG, 32'h5);
		tick(2);
		chkPwr(5'h05);
		wr(A_CFG, 32'h0);
		tick(2);
		chkPwr(5'h1b);
		pwmOn <= 9'h001;
	endtask : testOffPhase

	task testTrig();
		f = fires;
		u_lepsc_host_model.pullTrig();
		tick(2 * TICK);
		chk(fires - f, 32'h1);
		u_lepsc_host_model.pullTrig();
		tick(2 * TICK);
		chk(fires - f, 32'h2);
		w = lowCyc;
		engSendTrig <= 1'b1;
		tick(1);
		engSendTrig <= 1'b0;
		rdc(A_ST, 32'h16c);
		tick(6 * TICK);
		chk({31'h0, (lowCyc - w > 2 * TICK) && (lowCyc - w <= 3 * TICK)}, 32'h1);
		chk(fires - f, 32'h2);
		notifyReq <= 1'b1;
		tick(2);
		chk({31'h0, notifyPinOe_b}, 32'h0);
		notifyReq <= 1'b0;
		tick(2);
		chk({30'h0, notifyPinOe_b, syncTriggerPinOut | notifyPinOut}, 32'h2);
	endtask : testTrig

	task testDirect();
		wr(A_DIR, 32'h0001335a);
		tick(3);
		chk({24'h0, currentOutputEight}, 32'h5a);
		chk({24'h0, currentOutputNine}, 32'hc4);
		wr(A_DIR, 32'h0002335a);
		tick(3);
		chk({24'h0, currentOutputEight}, 32'h81);
		chk({24'h0, currentOutputNine}, 32'h33);
	endtask : testDirect

	task finishTest();
		if (mismatches == 0 && nTests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finishTest

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		engIdleCyc = '0;
		engPwmReq = 3'b000;
		pwmOn = 9'h001;
		engLevel8 = 8'h81;
		engLevel9 = 8'hc4;
		engSendTrig = 1'b0;
		notifyReq = 1'b0;
		tick(12);
		rst_b <= 1'b1;
		testRegs();
		testIdle();
		testOffPhase();
		testTrig();
		testDirect();
		finishTest();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		tick(20000);
		mismatches++;
		finishTest();
	end
endmodule : lepsc_power_save_bench
